// ---- rtl/cabu_pkg.sv ----
// Package of constants and types for the ALU and branch unit
package cabu_pkg;
  // Register addresses in the I/O space
  localparam logic [5:0] ADDR_SP_LO  = 6'h3D;
  localparam logic [5:0] ADDR_SP_HI  = 6'h3E;
  localparam logic [5:0] ADDR_FLAGS  = 6'h3F;
  localparam logic [5:0] BIT_IO_TOP  = 6'h1F;
  // Status flag positions
  localparam int FL_C = 0;
  localparam int FL_Z = 1;
  localparam int FL_N = 2;
  localparam int FL_V = 3;
  localparam int FL_S = 4;
  localparam int FL_H = 5;
  localparam int FL_T = 6;
  localparam int FL_I = 7;
  // Reset values
  localparam logic [7:0]  FLAGS_RST = 8'h00;
  localparam logic [15:0] SP_RST    = 16'h007F;
  localparam logic [21:0] PC_RST    = 22'h00_0000;
  // Extra cycles beyond the first, per operation class
  localparam logic [1:0] XC_BR_TAKEN = 2'd1;
  localparam logic [1:0] XC_SKIP_ONE = 2'd1;
  localparam logic [1:0] XC_SKIP_TWO = 2'd2;
  localparam logic [1:0] XC_JUMP     = 2'd1;
  localparam logic [1:0] XC_CALL     = 2'd2;
  localparam logic [1:0] XC_POP      = 2'd3;
  // Operation codes
  typedef enum logic [4:0] {
    OP_NOP, OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_BORROW, OP_AND, OP_OR, OP_XOR,
    OP_SET_MASK, OP_CLR_MASK, OP_TEST, OP_CMP_SKIP, OP_SKIP_RB_LO, OP_SKIP_RB_HI,
    OP_SKIP_IO_LO, OP_SKIP_IO_HI, OP_IO_SET, OP_IO_CLR, OP_BR_FLAG_HI, OP_BR_FLAG_LO,
    OP_BR_SGE, OP_BR_SLT, OP_BR_UGE, OP_BR_ULT, OP_JMP_REL, OP_JMP_PTR,
    OP_CALL_REL, OP_CALL_PTR, OP_POP_CALL, OP_POP_INT
  } cabu_op_t;
  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_PUSH = 4'b0100,
    ST_POP  = 4'b1000
  } cabu_state_t;
endpackage : cabu_pkg

// ---- rtl/cabu_alu_branch.sv ----
// Execution unit: ALU with flags, skips, branches, jumps, calls and returns
`timescale 1ns/1ps
module cabu_alu_branch
  import cabu_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        cmd_valid,
  output      logic        cmd_ready,
  input  wire cabu_op_t    cmd_op,
  input  wire logic [7:0]  cmd_rd,
  input  wire logic [7:0]  cmd_rr,
  input  wire logic [7:0]  cmd_imm,
  input  wire logic        cmd_use_imm,
  input  wire logic [2:0]  cmd_bit,
  input  wire logic [11:0] cmd_off,
  input  wire logic [15:0] cmd_ptr,
  input  wire logic [5:0]  cmd_io_addr,
  input  wire logic [7:0]  cmd_io_val,
  input  wire logic        cmd_next_long,
  output      logic        op_done,
  output      logic [7:0]  res_data,
  output      logic        res_we,
  output      logic [21:0] pc,
  output      logic [7:0]  flags,
  input  wire logic        reg_we,
  input  wire logic [5:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output      logic [7:0]  reg_rdata,
  output      logic        io_bit_we,
  output      logic [4:0]  io_bit_addr,
  output      logic [7:0]  io_bit_mask,
  output      logic        io_bit_val,
  output      logic        io_refused,
  output      logic [15:0] stk_addr,
  output      logic        stk_we,
  output      logic        stk_re,
  output      logic [7:0]  stk_wdata,
  input  wire logic [7:0]  stk_rdata
);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // Zero, negative, overflow and sign from a result and its overflow
  function automatic logic [3:0] fl_zsnv(input logic [7:0] r, input logic z_in, input logic v);
    fl_zsnv = {r[7] ^ v, v, r[7], z_in & (r == 8'h00)};
  endfunction : fl_zsnv

  cabu_state_t state;
  logic [1:0]  cnt;
  logic [15:0] sp;
  logic [15:0] ret_addr;
  logic [7:0]  ret_hi;
  logic        pop_int;

  ////////////////////////////////////////////////////////////////////////////
  // Operand and operation decoding
  wire        accept    = cmd_valid & (state == ST_IDLE);
  wire [7:0]  opb       = cmd_use_imm ? cmd_imm : cmd_rr;
  wire        op_sub    = (cmd_op == OP_SUB) | (cmd_op == OP_SUB_BORROW);
  wire        op_chain  = (cmd_op == OP_ADD_CARRY) | (cmd_op == OP_SUB_BORROW);
  wire        is_arith  = op_sub | (cmd_op == OP_ADD) | (cmd_op == OP_ADD_CARRY);
  wire        is_logic  = (cmd_op == OP_AND) | (cmd_op == OP_OR) | (cmd_op == OP_XOR)
                        | (cmd_op == OP_SET_MASK) | (cmd_op == OP_CLR_MASK)
                        | (cmd_op == OP_TEST);
  wire        is_io_bit = (cmd_op == OP_IO_SET) | (cmd_op == OP_IO_CLR)
                        | (cmd_op == OP_SKIP_IO_LO) | (cmd_op == OP_SKIP_IO_HI);
  wire        io_ok     = cmd_io_addr <= BIT_IO_TOP;
  wire        is_branch = (cmd_op >= OP_BR_FLAG_HI) & (cmd_op <= OP_BR_ULT);
  wire        is_call   = (cmd_op == OP_CALL_REL) | (cmd_op == OP_CALL_PTR);
  wire        is_pop    = (cmd_op == OP_POP_CALL) | (cmd_op == OP_POP_INT);

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic with carry, half carry and overflow
  wire        cin   = op_chain & flags[FL_C];
  wire [8:0]  add_r = {1'b0, cmd_rd} + {1'b0, opb} + {8'h00, cin};
  wire [8:0]  sub_r = {1'b0, cmd_rd} - {1'b0, opb} - {8'h00, cin};
  wire [7:0]  ar    = op_sub ? sub_r[7:0] : add_r[7:0];
  wire        a3    = cmd_rd[3];
  wire        b3    = opb[3];
  wire        a7    = cmd_rd[7];
  wire        b7    = opb[7];
  wire        h_add = (a3 & b3) | (b3 & ~ar[3]) | (~ar[3] & a3);
  wire        h_sub = (~a3 & b3) | (b3 & ar[3]) | (ar[3] & ~a3);
  wire        v_add = (a7 & b7 & ~ar[7]) | (~a7 & ~b7 & ar[7]);
  wire        v_sub = (a7 & ~b7 & ~ar[7]) | (~a7 & b7 & ar[7]);
  // Chained subtract keeps Z only if it was already set
  wire        z_in  = (cmd_op == OP_SUB_BORROW) ? flags[FL_Z] : 1'b1;
  wire [3:0]  ar_f  = fl_zsnv(ar, z_in, op_sub ? v_sub : v_add);
  wire        ar_c  = op_sub ? sub_r[8] : add_r[8];
  wire        ar_h  = op_sub ? h_sub : h_add;

  // Logic results; mask ops take the constant as mask
  wire [7:0]  lr = (cmd_op == OP_AND)      ? (cmd_rd & opb)
                 : (cmd_op == OP_OR)       ? (cmd_rd | opb)
                 : (cmd_op == OP_XOR)      ? (cmd_rd ^ opb)
                 : (cmd_op == OP_SET_MASK) ? (cmd_rd | cmd_imm)
                 : (cmd_op == OP_CLR_MASK) ? (cmd_rd & ~cmd_imm)
                 : (cmd_rd & cmd_rd);
  wire [3:0]  lr_f = fl_zsnv(lr, 1'b1, 1'b0);

  // Flag image after an ALU step, bit order I T H S V N Z C
  wire [7:0]  fl_ar = {flags[FL_I], flags[FL_T], ar_h, ar_f[3:1], ar_f[0], ar_c};
  wire [7:0]  fl_lr = {flags[FL_I], flags[FL_T], flags[FL_H], lr_f, flags[FL_C]};

  ////////////////////////////////////////////////////////////////////////////
  // Skip and branch conditions
  wire        rd_bit = cmd_rd[cmd_bit];
  wire        io_bit = cmd_io_val[cmd_bit];
  wire        sv     = flags[FL_N] ^ flags[FL_V];
  wire        skip_hit = (cmd_op == OP_CMP_SKIP)    ? (cmd_rd == cmd_rr)
                       : (cmd_op == OP_SKIP_RB_LO)  ? ~rd_bit
                       : (cmd_op == OP_SKIP_RB_HI)  ? rd_bit
                       : (cmd_op == OP_SKIP_IO_LO)  ? (io_ok & ~io_bit)
                       : (cmd_op == OP_SKIP_IO_HI)  ? (io_ok & io_bit)
                       : 1'b0;
  wire        br_hit = (cmd_op == OP_BR_FLAG_HI) ? flags[cmd_bit]
                     : (cmd_op == OP_BR_FLAG_LO) ? ~flags[cmd_bit]
                     : (cmd_op == OP_BR_SGE)     ? ~sv
                     : (cmd_op == OP_BR_SLT)     ? sv
                     : (cmd_op == OP_BR_UGE)     ? ~flags[FL_C]
                     : (cmd_op == OP_BR_ULT)     ? flags[FL_C]
                     : 1'b0;

  // Program counter targets
  wire [21:0] pc_inc  = pc + 22'd1;
  wire [21:0] rel_tgt = pc_inc + {{10{cmd_off[11]}}, cmd_off};
  wire [21:0] ptr_tgt = {6'h00, cmd_ptr};
  wire [21:0] skip_pc = pc + (cmd_next_long ? 22'd3 : 22'd2);
  wire [21:0] next_pc = (is_branch & br_hit) | (cmd_op == OP_JMP_REL)
                      | (cmd_op == OP_CALL_REL) ? rel_tgt
                      : (cmd_op == OP_JMP_PTR) | (cmd_op == OP_CALL_PTR) ? ptr_tgt
                      : skip_hit ? skip_pc
                      : pc_inc;

  // Extra cycles after the accepting one
  wire [1:0]  next_cnt = is_pop ? XC_POP
                       : is_call ? XC_CALL
                       : (cmd_op == OP_JMP_REL) | (cmd_op == OP_JMP_PTR) ? XC_JUMP
                       : (is_branch & br_hit) ? XC_BR_TAKEN
                       : skip_hit ? (cmd_next_long ? XC_SKIP_TWO : XC_SKIP_ONE)
                       : 2'd0;
  wire        sw_flags = reg_we & (reg_addr == ADDR_FLAGS);

  ////////////////////////////////////////////////////////////////////////////
  // Handshake and stack port
  assign cmd_ready = (state == ST_IDLE);
  assign op_done   = (accept & (next_cnt == 2'd0)) | ((state != ST_IDLE) & (cnt == 2'd1));
  assign stk_we    = (state == ST_PUSH);
  assign stk_re    = (state == ST_POP) & (cnt != 2'd1);
  assign stk_addr  = (state == ST_POP) ? sp + 16'd1 : sp;
  assign stk_wdata = (cnt == 2'd2) ? ret_addr[7:0] : ret_addr[15:8];

  // Sequencer
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      cnt   <= 2'd0;
    end else if (accept) begin
      cnt   <= next_cnt;
      state <= is_call ? ST_PUSH : is_pop ? ST_POP
             : (next_cnt != 2'd0) ? ST_WAIT : ST_IDLE;
    end else if (state != ST_IDLE) begin
      cnt   <= cnt - 2'd1;
      state <= (cnt == 2'd1) ? ST_IDLE : state;
    end
  end

  // Program counter, return address and stack pointer
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pc       <= PC_RST;
      sp       <= SP_RST;
      ret_addr <= 16'h0000;
      ret_hi   <= 8'h00;
      pop_int  <= 1'b0;
    end else begin
      if (reg_we & (reg_addr == ADDR_SP_LO))
        sp[7:0] <= reg_wdata;
      if (reg_we & (reg_addr == ADDR_SP_HI))
        sp[15:8] <= reg_wdata;
      if (accept) begin
        pc       <= is_pop ? pc : next_pc;
        ret_addr <= pc_inc[15:0];
        pop_int  <= (cmd_op == OP_POP_INT);
      end
      if (stk_we)
        sp <= sp - 16'd1;
      if (stk_re)
        sp <= sp + 16'd1;
      if ((state == ST_POP) & (cnt == 2'd2))
        ret_hi <= stk_rdata;
      if ((state == ST_POP) & (cnt == 2'd1))
        pc <= {6'h00, ret_hi, stk_rdata};
    end
  end

  // Status flags; hardware updates win over a software write
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      flags <= FLAGS_RST;
    end else if (accept & is_arith) begin
      flags <= fl_ar;
    end else if (accept & is_logic) begin
      flags <= fl_lr;
    end else if ((state == ST_POP) & (cnt == 2'd1) & pop_int) begin
      flags[FL_I] <= 1'b1;
    end else if (sw_flags) begin
      flags <= reg_wdata;
    end
  end

  // Result write and register read-back
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      res_data  <= 8'h00;
      res_we    <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      res_data  <= is_arith ? ar : lr;
      res_we    <= accept & (is_arith | (is_logic & (cmd_op != OP_TEST)));
      reg_rdata <= (reg_addr == ADDR_FLAGS) ? flags
                 : (reg_addr == ADDR_SP_HI) ? sp[15:8]
                 : (reg_addr == ADDR_SP_LO) ? sp[7:0] : 8'h00;
    end
  end

  // Single-bit I/O writes carry one mask bit only
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      io_bit_we   <= 1'b0;
      io_bit_addr <= 5'h00;
      io_bit_mask <= 8'h00;
      io_bit_val  <= 1'b0;
      io_refused  <= 1'b0;
    end else begin
      io_bit_we   <= accept & io_ok & ((cmd_op == OP_IO_SET) | (cmd_op == OP_IO_CLR));
      io_bit_addr <= cmd_io_addr[4:0];
      io_bit_mask <= 8'h01 << cmd_bit;
      io_bit_val  <= (cmd_op == OP_IO_SET);
      io_refused  <= accept & is_io_bit & ~io_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_arith_one_cycle: assert property (accept && is_arith |-> op_done ##1 res_we)
    else $error("arith op not done in one cycle");
  a_logic_keeps_carry: assert property (accept && is_logic && !sw_flags
    |=> flags[FL_C] == $past(flags[FL_C]) && flags[FL_H] == $past(flags[FL_H]))
    else $error("logic op changed C or H");
  a_test_zero_flag: assert property (accept && cmd_op == OP_TEST
    |=> flags[FL_Z] == ($past(cmd_rd) == 8'h00) && !res_we)
    else $error("test op flags wrong");
  a_skip_long_three: assert property (accept && skip_hit && cmd_next_long
    |-> !op_done ##1 !op_done ##1 op_done)
    else $error("long skip not three cycles");
  a_branch_taken_pc: assert property (accept && is_branch && br_hit
    |=> pc == $past(rel_tgt) && op_done)
    else $error("taken branch target or timing wrong");
  a_signed_ge_cond: assert property (accept && cmd_op == OP_BR_SGE
    |-> (next_cnt == 2'd1) == !(flags[FL_N] ^ flags[FL_V]))
    else $error("signed ge branch decision wrong");
  a_ptr_jump_pc: assert property (accept && cmd_op == OP_JMP_PTR
    |=> pc == {6'h00, $past(cmd_ptr)} && op_done)
    else $error("pointer jump wrong");
  a_call_push_len: assert property (accept && is_call
    |-> !op_done ##1 stk_we && !op_done ##1 stk_we && op_done)
    else $error("call not three cycles with two pushes");
  a_int_exit_sets: assert property (accept && cmd_op == OP_POP_INT
    |-> ##3 op_done ##1 flags[FL_I] && cmd_ready)
    else $error("interrupt exit timing or I flag wrong");
  a_io_high_refused: assert property (accept && is_io_bit && !io_ok
    |=> io_refused && !io_bit_we)
    else $error("high I/O bit access not refused");
  a_io_single_bit: assert property (io_bit_we |-> $onehot(io_bit_mask))
    else $error("bit write touches more than one bit");

endmodule : cabu_alu_branch

// ---- bench/cabu_stack_mem.sv ----
// Stack memory model on the far side of the execution unit
`timescale 1ns/1ps
module cabu_stack_mem (
  input  wire logic        core_clk,
  input  wire logic [15:0] stk_addr,
  input  wire logic        stk_we,
  input  wire logic        stk_re,
  input  wire logic [7:0]  stk_wdata,
  output      logic [7:0]  stk_rdata
);
  logic [7:0] mem [0:255];

  ////////////////////////////////////////////////////////////////////////////
  // Synchronous port; data toggles when not read so stale bytes never pass
  initial stk_rdata = 8'h00;
  always @(posedge core_clk) begin
    if (stk_we) begin
      mem[stk_addr[7:0]] <= stk_wdata;
    end
    if (stk_re) begin
      stk_rdata <= mem[stk_addr[7:0]];
    end else begin
      stk_rdata <= ~stk_rdata;
    end
  end
endmodule : cabu_stack_mem

// ---- bench/tb.sv ----
// Self-checking testbench for the ALU and branch unit
`timescale 1ns/1ps
module tb
  import cabu_pkg::*;
;
  logic        core_clk, arst_n, cmd_valid, cmd_ready, cmd_use_imm, cmd_next_long, op_done;
  logic        res_we, reg_we, io_bit_we, io_bit_val, io_refused, stk_we, stk_re;
  cabu_op_t    cmd_op;
  logic [7:0]  cmd_rd, cmd_rr, cmd_imm, cmd_io_val, res_data, flags, reg_wdata, reg_rdata;
  logic [7:0]  io_bit_mask, stk_wdata, stk_rdata;
  logic [2:0]  cmd_bit;
  logic [11:0] cmd_off;
  logic [15:0] cmd_ptr, stk_addr;
  logic [5:0]  cmd_io_addr, reg_addr;
  logic [4:0]  io_bit_addr;
  logic [21:0] pc, epc, ra;
  logic [7:0]  ef;
  int          err_total, compares;

  ////////////////////////////////////////////////////////////////////////////
  // Design and stack partner
  cabu_alu_branch i_cabu_alu_branch (.core_clk, .arst_n, .cmd_valid, .cmd_ready, .cmd_op,
    .cmd_rd, .cmd_rr, .cmd_imm, .cmd_use_imm, .cmd_bit, .cmd_off, .cmd_ptr, .cmd_io_addr,
    .cmd_io_val, .cmd_next_long, .op_done, .res_data, .res_we, .pc, .flags, .reg_we,
    .reg_addr, .reg_wdata, .reg_rdata, .io_bit_we, .io_bit_addr, .io_bit_mask, .io_bit_val,
    .io_refused, .stk_addr, .stk_we, .stk_re, .stk_wdata, .stk_rdata);
  cabu_stack_mem i_cabu_stack_mem (.core_clk, .stk_addr, .stk_we, .stk_re, .stk_wdata,
    .stk_rdata);

  ////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    #(25 * 3000);
    err_total++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare, verdict and access tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("errors=%0d compares=%0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_we    = 1'b1;
    @(negedge core_clk);
    reg_we = 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(negedge core_clk);
    reg_addr = a;
    @(negedge core_clk);
    #1 chk(reg_rdata, e);
  endtask : rd

  // One command: cycles to op_done, pc step and flags seen the cycle after
  task automatic go(input cabu_op_t o, input logic [7:0] a, input logic [7:0] b,
                    input logic [2:0] bt, input logic lng, input int nc,
                    input logic [21:0] dpc, input logic [7:0] fl);
    int   n;
    logic dn;
    @(negedge core_clk);
    cmd_op = o;
    cmd_rd = a;
    cmd_io_val = a;
    cmd_rr = b;
    cmd_imm = b;
    cmd_bit = bt;
    cmd_next_long = lng;
    cmd_valid = 1'b1;
    #1 n = 1;
    dn = op_done;
    while (dn !== 1'b1 && n < 8) begin
      @(negedge core_clk);
      cmd_valid = 1'b0;
      #1 n++;
      dn = op_done;
    end
    @(negedge core_clk);
    cmd_valid = 1'b0;
    #1 epc = epc + dpc;
    chk(n, nc);
    chk(pc, epc);
    chk(flags, fl);
  endtask : go

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    err_total = 0; compares = 0; epc = 22'h0; arst_n = 1'b0; cmd_valid = 1'b0;
    cmd_op = OP_NOP; cmd_rd = 8'h0; cmd_rr = 8'h0; cmd_imm = 8'h0; cmd_use_imm = 1'b0;
    cmd_bit = 3'h0; cmd_off = 12'h010; cmd_ptr = 16'h1234; cmd_io_addr = 6'h1F;
    cmd_io_val = 8'h0; cmd_next_long = 1'b0; reg_we = 1'b0; reg_addr = 6'h0; reg_wdata = 8'h0;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    arst_n = 1'b1;
    rd(ADDR_SP_LO, SP_RST[7:0]);
    rd(ADDR_SP_HI, SP_RST[15:8]);
    rd(ADDR_FLAGS, FLAGS_RST);
    rd(6'h10, 8'h00);
    go(OP_ADD, 8'h0F, 8'h01, 3'h0, 1'b0, 1, 22'h1, 8'h20);
    chk(res_data, 8'h10);
    go(OP_ADD, 8'h80, 8'h80, 3'h0, 1'b0, 1, 22'h1, 8'h1B);
    chk(res_we, 1'b1);
    go(OP_BR_SLT, 8'h0, 8'h0, 3'h0, 1'b0, 2, 22'h11, 8'h1B);
    go(OP_BR_SGE, 8'h0, 8'h0, 3'h0, 1'b0, 1, 22'h1, 8'h1B);
    go(OP_BR_ULT, 8'h0, 8'h0, 3'h0, 1'b0, 2, 22'h11, 8'h1B);
    go(OP_BR_UGE, 8'h0, 8'h0, 3'h0, 1'b0, 1, 22'h1, 8'h1B);
    ef = 8'h1B;
    for (int i = 0; i < 8; i++) begin
      go(OP_BR_FLAG_HI, 8'h0, 8'h0, 3'(i), 1'b0, ef[i] ? 2 : 1, ef[i] ? 22'h11 : 22'h1, ef);
      go(OP_BR_FLAG_LO, 8'h0, 8'h0, 3'(i), 1'b0, ef[i] ? 1 : 2, ef[i] ? 22'h1 : 22'h11, ef);
    end
    cmd_off = 12'hFF0;
    go(OP_BR_FLAG_HI, 8'h0, 8'h0, 3'h0, 1'b0, 2, 22'h3F_FFF1, ef);
    cmd_use_imm = 1'b1;
    go(OP_SUB, 8'h00, 8'h01, 3'h0, 1'b0, 1, 22'h1, 8'h35);
    go(OP_SUB_BORROW, 8'h05, 8'h02, 3'h0, 1'b0, 1, 22'h1, 8'h00);
    chk(res_data, 8'h02);
    go(OP_SUB, 8'h00, 8'h01, 3'h0, 1'b0, 1, 22'h1, 8'h35);
    go(OP_AND, 8'hF0, 8'h0F, 3'h0, 1'b0, 1, 22'h1, 8'h23);
    cmd_use_imm = 1'b0;
    go(OP_OR, 8'h80, 8'h01, 3'h0, 1'b0, 1, 22'h1, 8'h35);
    chk(res_data, 8'h81);
    go(OP_XOR, 8'hFF, 8'hFF, 3'h0, 1'b0, 1, 22'h1, 8'h23);
    go(OP_SET_MASK, 8'h01, 8'h80, 3'h0, 1'b0, 1, 22'h1, 8'h35);
    chk(res_data, 8'h81);
    go(OP_CLR_MASK, 8'hFF, 8'h0F, 3'h0, 1'b0, 1, 22'h1, 8'h35);
    chk(res_data, 8'hF0);
    go(OP_TEST, 8'h00, 8'h00, 3'h0, 1'b0, 1, 22'h1, 8'h23);
    chk(res_we, 1'b0);
    go(OP_CMP_SKIP, 8'h05, 8'h05, 3'h0, 1'b0, 2, 22'h2, 8'h23);
    go(OP_CMP_SKIP, 8'h05, 8'h06, 3'h0, 1'b0, 1, 22'h1, 8'h23);
    go(OP_CMP_SKIP, 8'h05, 8'h05, 3'h0, 1'b1, 3, 22'h3, 8'h23);
    go(OP_SKIP_RB_LO, 8'hF7, 8'h0, 3'h3, 1'b0, 2, 22'h2, 8'h23);
    go(OP_SKIP_RB_LO, 8'hFF, 8'h0, 3'h3, 1'b1, 1, 22'h1, 8'h23);
    go(OP_SKIP_RB_HI, 8'hF7, 8'h0, 3'h3, 1'b0, 1, 22'h1, 8'h23);
    go(OP_SKIP_RB_HI, 8'h08, 8'h0, 3'h3, 1'b1, 3, 22'h3, 8'h23);
    go(OP_SKIP_IO_LO, 8'hFB, 8'h0, 3'h2, 1'b0, 2, 22'h2, 8'h23);
    go(OP_SKIP_IO_HI, 8'h04, 8'h0, 3'h2, 1'b1, 3, 22'h3, 8'h23);
    go(OP_IO_SET, 8'h00, 8'h0, 3'h6, 1'b0, 1, 22'h1, 8'h23);
    chk({io_bit_we, io_bit_addr, io_bit_mask, io_bit_val, io_refused}, 16'hFD02);
    cmd_io_addr = 6'h00;
    go(OP_IO_CLR, 8'hFF, 8'h0, 3'h0, 1'b0, 1, 22'h1, 8'h23);
    chk({io_bit_we, io_bit_addr, io_bit_mask, io_bit_val, io_refused}, 16'h8004);
    cmd_io_addr = 6'h20;
    go(OP_IO_SET, 8'h00, 8'h0, 3'h1, 1'b0, 1, 22'h1, 8'h23);
    chk({io_bit_we, io_refused}, 2'b01);
    go(OP_SKIP_IO_HI, 8'hFF, 8'h0, 3'h2, 1'b0, 1, 22'h1, 8'h23);
    go(OP_JMP_PTR, 8'h0, 8'h0, 3'h0, 1'b0, 2, 22'h00_1234 - epc, 8'h23);
    cmd_off = 12'h010;
    ra = epc + 22'h1;
    go(OP_CALL_REL, 8'h0, 8'h0, 3'h0, 1'b0, 3, 22'h11, 8'h23);
    chk({i_cabu_stack_mem.mem[8'h7E], i_cabu_stack_mem.mem[8'h7F]}, ra[15:0]);
    rd(ADDR_SP_LO, 8'h7D);
    go(OP_POP_CALL, 8'h0, 8'h0, 3'h0, 1'b0, 4, ra - epc, 8'h23);
    ra = epc + 22'h1;
    cmd_ptr = 16'h0200;
    go(OP_CALL_PTR, 8'h0, 8'h0, 3'h0, 1'b0, 3, 22'h00_0200 - epc, 8'h23);
    go(OP_POP_INT, 8'h0, 8'h0, 3'h0, 1'b0, 4, ra - epc, 8'hA3);
    go(OP_ADD_CARRY, 8'h0E, 8'h01, 3'h0, 1'b0, 1, 22'h1, 8'hA0);
    chk(res_data, 8'h10);
    go(OP_JMP_REL, 8'h0, 8'h0, 3'h0, 1'b0, 2, 22'h11, 8'hA0);
    wr(ADDR_FLAGS, 8'h5A);
    rd(ADDR_FLAGS, 8'h5A);
    wr(ADDR_SP_LO, 8'h40);
    rd(ADDR_SP_LO, 8'h40);
    final_report();
  end
endmodule : tb
